// ---- hw/dma_cmd_pkg.sv ----
// Package: offsets, bit positions, reset values and decode helpers
package dma_cmd_pkg;

   // Register bus shape
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   // Byte offsets of the channel registers
   localparam logic [ADDR_W-1:0] DMA1_OPERATION_COMMAND = 12'hD00;
   localparam logic [ADDR_W-1:0] DMA1_INTERRUPT_CONTROL = 12'hD04;
   localparam logic [ADDR_W-1:0] DMA2_OPERATION_COMMAND = 12'hE00;
   localparam logic [ADDR_W-1:0] DMA2_INTERRUPT_CONTROL = 12'hE04;

   // Operation register bit positions
   localparam int START_BIT = 0;
   localparam int STOP_BIT = 2;
   localparam int ABORT_BIT = 3;
   localparam int FIFO_FLUSH_BIT = 4;
   localparam int COMPLETION_CLEAR_BIT = 7;

   // Interrupt control register bit positions
   localparam int CFG_READY_BIT = 14;
   localparam int COMPLETION_IE_CLEAR_BIT = 24;
   localparam int COMPLETION_IE_SET_BIT = 25;
   localparam int IRQ_ENABLE_CLEAR_BIT = 30;
   localparam int IRQ_ENABLE_SET_BIT = 31;

   // Values after hard reset
   localparam logic IRQ_ENABLE_RST = 1'b0;
   localparam logic COMPLETION_IE_RST = 1'b0;
   localparam logic CFG_READY_RST = 1'b0;
   localparam logic COMPLETION_RST = 1'b0;
   localparam logic FIFO_FLUSH_RST = 1'b1;

   // Register select codes
   typedef enum logic [1:0] {sel_none, sel_op, sel_ctl} reg_sel_type;

   // Channel run states
   typedef enum logic [2:0] {
      ch_idle, ch_run, ch_drain, ch_stopped, ch_aborted
   } chan_state_type;

   // Write bit qualified by its byte lane
   function automatic logic lane_bit(input logic [BE_W-1:0] be,
                                     input logic [DATA_W-1:0] d,
                                     input int pos);
      return be[pos/8] & d[pos];
   endfunction

   // Which register an address selects
   function automatic reg_sel_type reg_sel(input logic [ADDR_W-1:0] a);
      if (a == DMA1_OPERATION_COMMAND || a == DMA2_OPERATION_COMMAND) begin
         return sel_op;
      end else if (a == DMA1_INTERRUPT_CONTROL ||
                   a == DMA2_INTERRUPT_CONTROL) begin
         return sel_ctl;
      end else begin
         return sel_none;
      end
   endfunction

   // Which channel an address selects
   function automatic logic reg_chan(input logic [ADDR_W-1:0] a);
      if (a == DMA2_OPERATION_COMMAND || a == DMA2_INTERRUPT_CONTROL) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

endpackage

// ---- hw/chan_irq_ctrl.sv ----
// One channel's interrupt control register: set/clear enable pairs
module chan_irq_ctrl
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic wr_ctl,
   input wire logic [dma_cmd_pkg::BE_W-1:0] be,
   input wire logic [dma_cmd_pkg::DATA_W-1:0] wdata,
   output logic irq_en,
   output logic completion_irq_en,
   output logic cfg_ready,
   output logic [dma_cmd_pkg::DATA_W-1:0] ctl_readback
);

   import dma_cmd_pkg::*;

   logic next_irq_en;
   logic next_completion_irq_en;
   logic next_cfg_ready;

   // Set and clear strobes; a write of 0 leaves both enables alone, bit 14 takes the written value
   always_comb begin
      next_irq_en = irq_en;
      next_completion_irq_en = completion_irq_en;
      next_cfg_ready = cfg_ready;
      if (wr_ctl) begin
         if (lane_bit(be, wdata, IRQ_ENABLE_SET_BIT)) begin
            next_irq_en = 1'b1;
         end else if (lane_bit(be, wdata, IRQ_ENABLE_CLEAR_BIT)) begin
            next_irq_en = 1'b0;
         end
         if (lane_bit(be, wdata, COMPLETION_IE_SET_BIT)) begin
            next_completion_irq_en = 1'b1;
         end else if (lane_bit(be, wdata, COMPLETION_IE_CLEAR_BIT)) begin
            next_completion_irq_en = 1'b0;
         end
         if (be[CFG_READY_BIT/8]) begin
            next_cfg_ready = wdata[CFG_READY_BIT];
         end
      end
   end

   // Only the hard reset reaches these; soft reset is not an input
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_en <= IRQ_ENABLE_RST;
         completion_irq_en <= COMPLETION_IE_RST;
         cfg_ready <= CFG_READY_RST;
      end else if (ce) begin
         irq_en <= next_irq_en;
         completion_irq_en <= next_completion_irq_en;
         cfg_ready <= next_cfg_ready;
      end
   end

   // Readback: enables and their inverses, reserved bits zero
   always_comb begin
      ctl_readback = '0;
      ctl_readback[IRQ_ENABLE_SET_BIT] = irq_en;
      ctl_readback[IRQ_ENABLE_CLEAR_BIT] = ~irq_en;
      ctl_readback[COMPLETION_IE_SET_BIT] = completion_irq_en;
      ctl_readback[COMPLETION_IE_CLEAR_BIT] = ~completion_irq_en;
      ctl_readback[CFG_READY_BIT] = cfg_ready;
   end

endmodule

// ---- hw/dma_command_control.sv ----
// Command and interrupt-enable logic for two DMA channels
//
// How it works
// - Both registers of each channel take 32, 16 and 8-bit accesses.
// - Operation bits 31-8 and 6-5 are written zero; they read zero.
// - Writing 1 to operation bit 7 clears completion; self-clearing.
// - Starting a new operation clears the completion flag.
// - Writing 1 to operation bit 4 pulses a FIFO flush; self-clearing.
// - Hard reset flushes the FIFO; soft reset leaves it alone.
// - Writing 1 to operation bit 3 aborts the operation at once.
// - The abort state clears when a new operation starts.
// - Bit 2 stops source reads now; destination drains, then halts.
// - Start after a stop resumes the same operation to completion.
// - The stop state clears when start is written.
// - A start write clears completion and begins the operation.
// - Both channels share one interrupt, each with its own enable.
// - Control bit 31 write 1 enables the interrupt; reads the enable.
// - Control bit 30 write 1 disables the interrupt; reads inverse.
// - Hard reset disables the interrupt; soft reset leaves it.
// - Control bits 25/24 set and clear the completion interrupt enable.
// - Control bit 14 hard-resets to 0; must be 1 for channel to run.
module dma_command_control
#(
   parameter int CHANNELS = 2
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic soft_reset,
   input wire logic [dma_cmd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [dma_cmd_pkg::BE_W-1:0] reg_be,
   input wire logic [dma_cmd_pkg::DATA_W-1:0] reg_wdata,
   output logic [dma_cmd_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_ack,
   input wire logic [CHANNELS-1:0] fifo_empty,
   input wire logic [CHANNELS-1:0] xfer_finished,
   input wire logic [CHANNELS-1:0] xfer_error,
   output logic [CHANNELS-1:0] op_start,
   output logic [CHANNELS-1:0] op_resume,
   output logic [CHANNELS-1:0] op_abort,
   output logic [CHANNELS-1:0] fifo_flush,
   output logic [CHANNELS-1:0] src_read_en,
   output logic [CHANNELS-1:0] dst_write_en,
   output logic [CHANNELS-1:0] completion_flag,
   output logic [CHANNELS-1:0] completion_irq_en,
   output logic [CHANNELS-1:0] chan_cfg_ready,
   output logic dma_irq
);

   import dma_cmd_pkg::*;

   // Bus decode shared by the write and read paths
   reg_sel_type sel;
   logic sel_ch;
   logic wr_take;
   logic rd_take;

   // Channel state and its next values
   chan_state_type state [CHANNELS];
   chan_state_type next_state [CHANNELS];
   logic [CHANNELS-1:0] stop_held;
   logic [CHANNELS-1:0] next_stop_held;
   logic [CHANNELS-1:0] abort_held;
   logic [CHANNELS-1:0] next_abort_held;
   logic [CHANNELS-1:0] next_completion_flag;
   logic [CHANNELS-1:0] next_op_start;
   logic [CHANNELS-1:0] next_op_resume;
   logic [CHANNELS-1:0] next_op_abort;
   logic [CHANNELS-1:0] next_fifo_flush;
   logic [CHANNELS-1:0] next_src_read_en;
   logic [CHANNELS-1:0] next_dst_write_en;

   // Per-channel control register outputs
   logic [CHANNELS-1:0] irq_en;
   logic [CHANNELS-1:0] wr_ctl;
   logic [dma_cmd_pkg::DATA_W-1:0] ctl_readback [CHANNELS];

   // Bus answer state
   logic [dma_cmd_pkg::DATA_W-1:0] next_reg_rdata;
   logic next_reg_ack;
   logic next_dma_irq;

   // Write strobe aimed at one register kind of one channel
   function automatic logic reg_hit(input logic take,
                                    input reg_sel_type s,
                                    input logic ch,
                                    input reg_sel_type want,
                                    input int c);
      return take && s == want && ch == c[0];
   endfunction

   // Address decode, once for both paths
   always_comb begin
      sel = reg_sel(reg_addr);
      sel_ch = reg_chan(reg_addr);
      wr_take = ce & reg_wr;
      rd_take = ce & reg_rd;
   end

   // Control register write strobe per channel
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         wr_ctl[c] = reg_hit(wr_take, sel, sel_ch, sel_ctl, c);
      end
   end

   // Control registers, one per channel
   for (genvar g = 0; g < CHANNELS; g++) begin : gen_ctl
      chan_irq_ctrl u_ctl (
         .clk(clk),
         .rstn(rstn),
         .ce(ce),
         .wr_ctl(wr_ctl[g]),
         .be(reg_be),
         .wdata(reg_wdata),
         .irq_en(irq_en[g]),
         .completion_irq_en(completion_irq_en[g]),
         .cfg_ready(chan_cfg_ready[g]),
         .ctl_readback(ctl_readback[g])
      );
   end

   // Channel command sequencing
   always_comb begin
      logic wr_op;
      logic cmd_start;
      logic cmd_stop;
      logic cmd_abort;
      wr_op = 1'b0;
      cmd_start = 1'b0;
      cmd_stop = 1'b0;
      cmd_abort = 1'b0;
      for (int c = 0; c < CHANNELS; c++) begin
         next_state[c] = state[c];
         next_stop_held[c] = stop_held[c];
         next_abort_held[c] = abort_held[c];
         next_completion_flag[c] = completion_flag[c];
         next_op_start[c] = 1'b0;
         next_op_resume[c] = 1'b0;
         next_op_abort[c] = 1'b0;
         wr_op = reg_hit(wr_take, sel, sel_ch, sel_op, c);
         // Start is refused until the channel is configured
         cmd_start = wr_op & lane_bit(reg_be, reg_wdata, START_BIT)
                     & chan_cfg_ready[c];
         cmd_stop = wr_op & lane_bit(reg_be, reg_wdata, STOP_BIT);
         cmd_abort = wr_op & lane_bit(reg_be, reg_wdata, ABORT_BIT);
         // Flush strobe lasts one cycle
         next_fifo_flush[c] = wr_op
            & lane_bit(reg_be, reg_wdata, FIFO_FLUSH_BIT);
         // Clear first, so a same-cycle completion event wins below
         if (wr_op & lane_bit(reg_be, reg_wdata, COMPLETION_CLEAR_BIT)) begin
            next_completion_flag[c] = 1'b0;
         end
         case (state[c])
            // Idle or aborted: only a configured start moves on
            ch_idle, ch_aborted: begin
               if (cmd_start) begin
                  next_state[c] = ch_run;
                  next_op_start[c] = 1'b1;
                  next_completion_flag[c] = 1'b0;
                  next_stop_held[c] = 1'b0;
                  next_abort_held[c] = 1'b0;
               end
            end
            // Running: abort beats end of transfer beats stop
            ch_run: begin
               if (cmd_abort) begin
                  next_state[c] = ch_aborted;
                  next_op_abort[c] = 1'b1;
                  next_abort_held[c] = 1'b1;
               end else if (xfer_error[c] | xfer_finished[c]) begin
                  next_state[c] = ch_idle;
                  next_completion_flag[c] = 1'b1;
               end else if (cmd_stop) begin
                  next_state[c] = ch_drain;
                  next_stop_held[c] = 1'b1;
               end
            end
            // Draining: destination empties the FIFO, then halt
            ch_drain: begin
               if (cmd_abort) begin
                  next_state[c] = ch_aborted;
                  next_op_abort[c] = 1'b1;
                  next_abort_held[c] = 1'b1;
               end else if (xfer_error[c]) begin
                  next_state[c] = ch_idle;
                  next_completion_flag[c] = 1'b1;
               end else if (fifo_empty[c]) begin
                  next_state[c] = ch_stopped;
                  next_completion_flag[c] = 1'b1;
               end
            end
            // Stopped: start resumes, abort discards
            ch_stopped: begin
               if (cmd_abort) begin
                  next_state[c] = ch_aborted;
                  next_op_abort[c] = 1'b1;
                  next_abort_held[c] = 1'b1;
               end else if (cmd_start) begin
                  next_state[c] = ch_run;
                  next_op_resume[c] = 1'b1;
                  next_completion_flag[c] = 1'b0;
                  next_stop_held[c] = 1'b0;
               end
            end
            default: begin
               next_state[c] = ch_idle;
            end
         endcase
         // Soft reset halts sequencing; FIFO and enables untouched
         if (soft_reset) begin
            next_state[c] = ch_idle;
            next_stop_held[c] = 1'b0;
            next_abort_held[c] = 1'b0;
            next_op_start[c] = 1'b0;
            next_op_resume[c] = 1'b0;
         end
         // Source reads only while running; writes also while draining
         next_src_read_en[c] = next_state[c] == ch_run;
         next_dst_write_en[c] = next_state[c] == ch_run
                                || next_state[c] == ch_drain;
      end
   end

   // Channel state registers; hard reset flushes the FIFO
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int c = 0; c < CHANNELS; c++) begin
            state[c] <= ch_idle;
         end
         stop_held <= '0;
         abort_held <= '0;
         completion_flag <= {CHANNELS{COMPLETION_RST}};
         op_start <= '0;
         op_resume <= '0;
         op_abort <= '0;
         fifo_flush <= {CHANNELS{FIFO_FLUSH_RST}};
         src_read_en <= '0;
         dst_write_en <= '0;
      end else if (ce) begin
         for (int c = 0; c < CHANNELS; c++) begin
            state[c] <= next_state[c];
         end
         stop_held <= next_stop_held;
         abort_held <= next_abort_held;
         completion_flag <= next_completion_flag;
         op_start <= next_op_start;
         op_resume <= next_op_resume;
         op_abort <= next_op_abort;
         fifo_flush <= next_fifo_flush;
         src_read_en <= next_src_read_en;
         dst_write_en <= next_dst_write_en;
      end
   end

   // Read mux and bus answer; unmapped addresses read zero
   always_comb begin
      next_reg_rdata = reg_rdata;
      next_reg_ack = reg_wr | reg_rd;
      if (rd_take) begin
         next_reg_rdata = '0;
         if (sel == sel_op) begin
            next_reg_rdata[STOP_BIT] = stop_held[sel_ch];
            next_reg_rdata[ABORT_BIT] = abort_held[sel_ch];
         end else if (sel == sel_ctl) begin
            next_reg_rdata = ctl_readback[sel_ch];
         end
         // Lanes not enabled read zero
         for (int b = 0; b < BE_W; b++) begin
            if (!reg_be[b]) begin
               next_reg_rdata[b*8 +: 8] = 8'h00;
            end
         end
      end
   end

   // Shared interrupt: any channel enabled twice over and complete
   always_comb begin
      next_dma_irq = |(irq_en & completion_irq_en & completion_flag);
   end

   // Bus answer and interrupt registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
         reg_ack <= 1'b0;
         dma_irq <= 1'b0;
      end else if (ce) begin
         reg_rdata <= next_reg_rdata;
         reg_ack <= next_reg_ack;
         dma_irq <= next_dma_irq;
      end
   end

endmodule

// ---- tb/dma_engine_model.sv ----
// Behavioural transfer engine facing the command block
module dma_engine_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] src_read_en,
   input wire logic [1:0] dst_write_en,
   input wire logic [1:0] fifo_flush,
   input wire logic [1:0] fin_cmd,
   input wire logic [1:0] err_cmd,
   output logic [1:0] fifo_empty,
   output logic [1:0] xfer_finished,
   output logic [1:0] xfer_error
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] fill [2];

   // Reads fill the FIFO; a drain-only phase empties it slowly
   always @(posedge clk or negedge rstn) begin
      for (int c = 0; c < 2; c++) begin
         if (!rstn || fifo_flush[c]) begin
            fill[c] <= 3'h0;
         end else if (src_read_en[c] && fill[c] != 3'h7) begin
            fill[c] <= fill[c] + 3'h1;
         end else if (dst_write_en[c] && fill[c] != 3'h0) begin
            fill[c] <= fill[c] - 3'h1;
         end
      end
   end

   assign fifo_empty = {fill[1] == 3'h0, fill[0] == 3'h0};

   // End-of-transfer pulses one cycle after the bench asks
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         xfer_finished <= 2'h0;
         xfer_error <= 2'h0;
      end else begin
         xfer_finished <= fin_cmd;
         xfer_error <= err_cmd;
      end
   end
endmodule

// ---- tb/dma_command_control_asserts.sv ----
// Port-level timing checks for the DMA command block
module dma_command_control_asserts
   import dma_cmd_pkg::*;
#(
   parameter int CHANNELS = 2
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic soft_reset,
   input wire logic [dma_cmd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [dma_cmd_pkg::BE_W-1:0] reg_be,
   input wire logic [dma_cmd_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [CHANNELS-1:0] fifo_empty,
   input wire logic [CHANNELS-1:0] xfer_finished,
   input wire logic [CHANNELS-1:0] xfer_error,
   input wire logic [CHANNELS-1:0] op_start,
   input wire logic [CHANNELS-1:0] op_resume,
   input wire logic [CHANNELS-1:0] op_abort,
   input wire logic [CHANNELS-1:0] fifo_flush,
   input wire logic [CHANNELS-1:0] src_read_en,
   input wire logic [CHANNELS-1:0] dst_write_en,
   input wire logic [CHANNELS-1:0] completion_flag,
   input wire logic [CHANNELS-1:0] completion_irq_en,
   input wire logic dma_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic w_op;
   logic irq_cause;

   // Low byte write to channel 1 operation register
   assign w_op = ce && reg_wr && reg_be[0] &&
      reg_addr == DMA1_OPERATION_COMMAND;
   assign irq_cause = |(completion_flag & completion_irq_en);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_drain; !src_read_en[0] && dst_write_en[0]; endsequence
   sequence s_halt; !src_read_en[0] && !dst_write_en[0]; endsequence

   property p_ack; ce && (reg_wr || reg_rd) |=> reg_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_start; op_start[0] |-> !completion_flag[0] && src_read_en[0];
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_clr;
      w_op && reg_wdata[7] && !dst_write_en[0] |=> !completion_flag[0];
   endproperty
   a_clr: assert property (p_clr) else $error("done kept");
   property p_flush;
      w_op && reg_wdata[4] |=> fifo_flush[0] ##1 !fifo_flush[0];
   endproperty
   a_flush: assert property (p_flush) else $error("bad flush");
   property p_abort;
      w_op && reg_wdata[3] && dst_write_en[0] |=> op_abort[0] ##0 s_halt;
   endproperty
   a_abort: assert property (p_abort) else $error("bad abort");
   property p_stop;
      w_op && reg_wdata[2] && !reg_wdata[3] && src_read_en[0] &&
      !xfer_finished[0] && !xfer_error[0] && !soft_reset |=> s_drain;
   endproperty
   a_stop: assert property (p_stop) else $error("bad stop");
   property p_drained;
      s_drain ##0 (ce && fifo_empty[0] && !w_op && !soft_reset)
      |=> s_halt ##0 completion_flag[0];
   endproperty
   a_drained: assert property (p_drained) else $error("no halt");
   property p_fin;
      ce && src_read_en[0] && xfer_finished[0] && !w_op && !soft_reset
      |=> completion_flag[0] ##0 s_halt;
   endproperty
   a_fin: assert property (p_fin) else $error("no done");
   property p_resume; op_resume[0] |-> src_read_en[0] && !completion_flag[0];
   endproperty
   a_resume: assert property (p_resume) else $error("bad resume");
   property p_irq; dma_irq |-> $past(irq_cause); endproperty
   a_irq: assert property (p_irq) else $error("stray irq");
endmodule

// ---- tb/dma_command_control_tb.sv ----
// Self-checking bench for the DMA command block
module dma_command_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dma_cmd_pkg::*;
   logic clk, rstn, ce, soft_reset, reg_wr, reg_rd, reg_ack, dma_irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [BE_W-1:0] reg_be;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [1:0] fifo_empty, xfer_finished, xfer_error, op_start, op_resume;
   logic [1:0] op_abort, fifo_flush, src_read_en, dst_write_en;
   logic [1:0] completion_flag, completion_irq_en, chan_cfg_ready;
   logic [1:0] fin_cmd, err_cmd;
   int err_total = 0;
   int n_compared = 0;

   dma_command_control #(.CHANNELS(2)) i_dut (.clk(clk), .rstn(rstn),
      .ce(ce), .soft_reset(soft_reset), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .fifo_empty(fifo_empty), .xfer_finished(xfer_finished),
      .xfer_error(xfer_error), .op_start(op_start), .op_resume(op_resume),
      .op_abort(op_abort), .fifo_flush(fifo_flush),
      .src_read_en(src_read_en), .dst_write_en(dst_write_en),
      .completion_flag(completion_flag),
      .completion_irq_en(completion_irq_en),
      .chan_cfg_ready(chan_cfg_ready), .dma_irq(dma_irq));

   dma_engine_model i_eng (.clk(clk), .rstn(rstn),
      .src_read_en(src_read_en), .dst_write_en(dst_write_en),
      .fifo_flush(fifo_flush), .fin_cmd(fin_cmd), .err_cmd(err_cmd),
      .fifo_empty(fifo_empty), .xfer_finished(xfer_finished),
      .xfer_error(xfer_error));

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One register access, answered at the next edge
   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [3:0] b, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_be <= b;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      chk(reg_ack, 32'h1);
   endtask

   task automatic wr(input logic [11:0] a, input logic [3:0] b,
                     input logic [31:0] d);
      acc(1'b1, a, b, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [3:0] b,
                     input logic [31:0] exp);
      acc(1'b0, a, b, 32'h0);
      chk(reg_rdata, exp);
   endtask

   task automatic wait_done(input int c);
      for (int i = 0; i < 40 && completion_flag[c] !== 1'b1; i++) cyc(1);
      chk(completion_flag[c], 32'h1);
   endtask

   task automatic hard_reset;
      @(posedge clk);
      rstn <= 1'b0;
      ce <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk(fifo_flush, 32'h3);
      @(posedge clk);
      rstn <= 1'b1;
      cyc(2);
      chk(fifo_flush, 32'h3);
      @(posedge clk);
      ce <= 1'b1;
      rd(DMA1_INTERRUPT_CONTROL, 4'hF, 32'h4100_0000);
      chk(fifo_flush, 32'h0);
      rd(DMA2_INTERRUPT_CONTROL, 4'hF, 32'h4100_0000);
      rd(DMA1_OPERATION_COMMAND, 4'hF, 32'h0);
      wr(DMA1_OPERATION_COMMAND, 4'h1, 32'h1);
      chk(op_start, 32'h0);
   endtask

   task automatic t_ctl;
      wr(DMA1_INTERRUPT_CONTROL, 4'hF, 32'h8200_4000);
      rd(DMA1_INTERRUPT_CONTROL, 4'hF, 32'h8200_4000);
      wr(DMA1_INTERRUPT_CONTROL, 4'h8, 32'h0);
      rd(DMA1_INTERRUPT_CONTROL, 4'h8, 32'h8200_0000);
      chk(completion_irq_en, 32'h1);
      rd(12'hD08, 4'hF, 32'h0);
      wr(DMA2_INTERRUPT_CONTROL, 4'h2, 32'h4000);
      chk(chan_cfg_ready, 32'h3);
   endtask

   task automatic t_stop;
      wr(DMA1_OPERATION_COMMAND, 4'h1, 32'h1);
      chk(op_start, 32'h1);
      cyc(4);
      wr(DMA1_OPERATION_COMMAND, 4'h3, 32'h4);
      chk({src_read_en[0], dst_write_en[0]}, 32'h1);
      rd(DMA1_OPERATION_COMMAND, 4'hF, 32'h4);
      wait_done(0);
      cyc(1);
      chk(dma_irq, 32'h1);
      wr(DMA1_OPERATION_COMMAND, 4'h1, 32'h1);
      chk(op_resume, 32'h1);
      chk(completion_flag, 32'h0);
      rd(DMA1_OPERATION_COMMAND, 4'hF, 32'h0);
      fin_cmd <= 2'b01;
      cyc(1);
      fin_cmd <= 2'b00;
      wait_done(0);
      wr(DMA1_OPERATION_COMMAND, 4'h1, 32'h80);
      chk(completion_flag, 32'h0);
      cyc(1);
      chk(dma_irq, 32'h0);
      wr(DMA1_OPERATION_COMMAND, 4'h1, 32'h1);
      wr(DMA1_OPERATION_COMMAND, 4'h1, 32'h8);
      chk(op_abort, 32'h1);
      wr(DMA1_OPERATION_COMMAND, 4'h1, 32'h10);
      chk(fifo_flush, 32'h1);
   endtask

   task automatic t_abort;
      wr(DMA2_OPERATION_COMMAND, 4'h1, 32'h1);
      chk(op_start, 32'h2);
      cyc(3);
      wr(DMA2_OPERATION_COMMAND, 4'h1, 32'h8);
      chk({op_abort[1], src_read_en[1], dst_write_en[1]}, 32'h4);
      rd(DMA2_OPERATION_COMMAND, 4'hF, 32'h8);
      wr(DMA2_OPERATION_COMMAND, 4'h1, 32'h10);
      chk(fifo_flush, 32'h2);
      cyc(1);
      chk(fifo_flush, 32'h0);
      wr(DMA2_OPERATION_COMMAND, 4'h1, 32'h1);
      rd(DMA2_OPERATION_COMMAND, 4'hF, 32'h0);
      err_cmd <= 2'b10;
      cyc(1);
      err_cmd <= 2'b00;
      wait_done(1);
      cyc(1);
      chk(dma_irq, 32'h0);
      wr(DMA2_INTERRUPT_CONTROL, 4'hF, 32'h8200_4000);
      cyc(1);
      chk(dma_irq, 32'h1);
      wr(DMA1_INTERRUPT_CONTROL, 4'h8, 32'h4000_0000);
      rd(DMA1_INTERRUPT_CONTROL, 4'hF, 32'h4200_4000);
   endtask

   task automatic t_soft;
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      cyc(1);
      chk(completion_flag, 32'h2);
      chk(fifo_flush, 32'h0);
      rd(DMA2_INTERRUPT_CONTROL, 4'hF, 32'h8200_4000);
   endtask

   task automatic test_done;
      if (err_total == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog well past the expected hundred or so cycles
   initial begin
      #(50 * 3000);
      err_total++;
      test_done;
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      soft_reset = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_be = '0;
      reg_wdata = '0;
      fin_cmd = 2'b00;
      err_cmd = 2'b00;
      hard_reset;
      t_ctl;
      t_stop;
      t_abort;
      t_soft;
      hard_reset;
      test_done;
   end
endmodule

bind dma_command_control dma_command_control_asserts #(.CHANNELS(CHANNELS))
   i_chk (.clk(clk), .rstn(rstn), .ce(ce), .soft_reset(soft_reset),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
   .reg_wdata(reg_wdata), .reg_ack(reg_ack), .fifo_empty(fifo_empty),
   .xfer_finished(xfer_finished), .xfer_error(xfer_error),
   .op_start(op_start), .op_resume(op_resume), .op_abort(op_abort),
   .fifo_flush(fifo_flush), .src_read_en(src_read_en),
   .dst_write_en(dst_write_en), .completion_flag(completion_flag),
   .completion_irq_en(completion_irq_en), .dma_irq(dma_irq));
